// ===== logic/sas_pkg.sv
// shared constants and types of the simultaneous sampling sequencer
package sas_pkg;
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned CONV_TIME_NS    = 1650;
   localparam int unsigned CONV_CYC        = CONV_TIME_NS * CLK_MHZ / 1000;
   localparam int unsigned EXT_CONV_CYC    = 14;
   localparam int unsigned ACQ_TIME_NS     = 350;
   localparam int unsigned ACQ_CYC         =
      (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned READ_GUARD_NS   = 100;
   localparam int unsigned READ_GUARD_CYC  =
      (READ_GUARD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned EOC_PULSE_CYC   = 2;
   localparam int unsigned DATA_W          = 12;
   localparam int unsigned NCH             = 4;
   localparam logic [3:0]  CHSEL_RST       = 4'hF;
   localparam int unsigned CHSEL_LSB       = 0;
   typedef enum logic [1:0] {
      SAS_IDLE = 2'b00,
      SAS_CONV = 2'b01,
      SAS_NEXT = 2'b10
   } sas_state_e;
   typedef enum logic [2:0] {
      SAH_IDLE  = 3'b000,
      SAH_START = 3'b001,
      SAH_WAIT  = 3'b010,
      SAH_READ  = 3'b011,
      SAH_REL   = 3'b100,
      SAH_WR    = 3'b101,
      SAH_ACQ   = 3'b110
   } sah_state_e;
endpackage

// ===== logic/sas_if.sv
// pin-level link between converter sequencer and its host
`timescale 1ns/1ps
interface sas_if;
   logic        conv_start_n;
   logic        cs_n;
   logic        rd_n;
   logic        wr_n;
   logic        busy;
   logic        eoc_n;
   logic [11:0] db_dev_o;
   logic        db_dev_oe;
   logic [11:0] db_host_o;
   logic        db_host_oe;
   logic [11:0] db;
   // wire level resolved from the enables; idle bus reads as zero here
   assign db = db_dev_oe ? db_dev_o : (db_host_oe ? db_host_o : 12'h000);
   modport dev (
      input  conv_start_n, cs_n, rd_n, wr_n, db_host_o, db_host_oe,
      output busy, eoc_n, db_dev_o, db_dev_oe
   );
   modport host (
      input  busy, eoc_n, db_dev_o, db_dev_oe,
      output conv_start_n, cs_n, rd_n, wr_n, db_host_o, db_host_oe
   );
endinterface

// ===== logic/sas_buf2.sv
// two-entry valid/ready buffer on the result path
`timescale 1ns/1ps
module sas_buf2 #(
   parameter int unsigned W = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_reg [2];
   logic         wp_reg;
   logic         rp_reg;
   logic [1:0]   cnt_reg;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;
   assign in_ready  = (cnt_reg != 2'd2);
   assign out_valid = (cnt_reg != 2'd0);
   assign out_data  = mem_reg[rp_reg];
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'd0;
      end else begin
         if (push) wp_reg <= ~wp_reg;
         if (pop) rp_reg <= ~rp_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge clk_sys) begin
      if (push) mem_reg[wp_reg] <= in_data;
   end
endmodule

// ===== logic/sas_dev.sv
// converter end: sequencing, channel select register, result readout
`timescale 1ns/1ps
module sas_dev
   import sas_pkg::*;
#(
   parameter bit TWOS_COMP = 1'b1
) (
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   sas_if.dev                     bus,
   input  wire logic [NCH-1:0]    chan_select_pins,
   input  wire logic              hw_sw_select,
   input  wire logic              clock_source_select,
   input  wire logic              ext_conv_clock,
   input  wire logic [NCH*DATA_W-1:0] sample_in,
   output logic [NCH-1:0]         track_hold_n,
   output logic                   seq_overflow
);
   // ==========================================================
   // start edge, clock selection
   // ==========================================================
   logic              start_d_reg;
   logic              ext_d_reg;
   wire               start_rise = bus.conv_start_n && !start_d_reg;
   wire               ext_rise   = ext_conv_clock && !ext_d_reg;
   wire               use_ext    = clock_source_select;
   wire  [NCH-1:0]    sel_now;
   logic [NCH-1:0]    chsel_reg;
   assign sel_now = hw_sw_select ? chsel_reg : chan_select_pins;

   // ==========================================================
   // channel select register write
   // ==========================================================
   wire wr_hit = !bus.cs_n && !bus.wr_n && bus.db_host_oe;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) chsel_reg <= CHSEL_RST;
      else if (wr_hit)
         chsel_reg <= bus.db_host_o[CHSEL_LSB +: NCH];
   end

   // ==========================================================
   // sequencer
   // ==========================================================
   sas_state_e        st_reg;
   logic [NCH-1:0]    pend_reg;
   logic [NCH*DATA_W-1:0] held_reg;
   logic [1:0]        ch_reg;
   logic [11:0]       tick_reg;
   logic              busy_reg;
   logic [NCH-1:0]    th_reg;
   logic [1:0]        eoc_cnt_reg;
   logic              eoc_n_reg;
   // lowest pending channel first
   wire  [1:0] first_ch = pend_reg[0] ? 2'd0 : pend_reg[1] ? 2'd1 :
                          pend_reg[2] ? 2'd2 : 2'd3;
   wire  [11:0] conv_len = use_ext ? 12'(EXT_CONV_CYC)
                                   : 12'(CONV_CYC);
   wire  conv_tick = use_ext ? ext_rise : 1'b1;
   wire  conv_done = (st_reg == SAS_CONV) && conv_tick
                     && (tick_reg == conv_len - 12'd1);
   wire  [NCH-1:0] pend_after = pend_reg & ~(4'h1 << ch_reg);
   wire  [DATA_W-1:0] raw = held_reg[ch_reg*DATA_W +: DATA_W];
   wire  [DATA_W-1:0] coded = TWOS_COMP ? {~raw[DATA_W-1], raw[DATA_W-2:0]}
                                        : raw;
   logic in_ready;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         start_d_reg <= 1'b1;
         ext_d_reg   <= 1'b0;
      end else begin
         start_d_reg <= bus.conv_start_n;
         ext_d_reg   <= ext_conv_clock;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg   <= SAS_IDLE;
         pend_reg <= '0;
         held_reg <= '0;
         ch_reg   <= 2'd0;
         tick_reg <= 12'd0;
         busy_reg <= 1'b0;
         th_reg   <= '1;
      end else begin
         case (st_reg)
            SAS_IDLE: begin
               if (start_rise) begin
                  th_reg   <= '0;
                  held_reg <= sample_in;
                  pend_reg <= sel_now;
                  busy_reg <= |sel_now;
                  if (|sel_now) st_reg <= SAS_NEXT;
                  else th_reg <= '1;
               end
            end
            SAS_NEXT: begin
               if (pend_reg == '0) begin
                  st_reg   <= SAS_IDLE;
                  busy_reg <= 1'b0;
                  th_reg   <= '1;
               end else begin
                  ch_reg   <= first_ch;
                  tick_reg <= 12'd0;
                  st_reg   <= SAS_CONV;
               end
            end
            SAS_CONV: begin
               if (conv_done) begin
                  pend_reg <= pend_after;
                  st_reg   <= SAS_NEXT;
               end else if (conv_tick) begin
                  tick_reg <= tick_reg + 12'd1;
               end
            end
            default: st_reg <= SAS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // end-of-conversion pulse
   // ==========================================================
   wire eoc_fire = conv_done;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         eoc_cnt_reg <= 2'd0;
         eoc_n_reg   <= 1'b1;
      end else if (eoc_fire) begin
         eoc_cnt_reg <= 2'(EOC_PULSE_CYC - 1);
         eoc_n_reg   <= 1'b0;
      end else if (eoc_cnt_reg != 2'd0) begin
         eoc_cnt_reg <= eoc_cnt_reg - 2'd1;
      end else begin
         eoc_n_reg   <= 1'b1;
      end
   end

   // ==========================================================
   // result store
   // ==========================================================
   // every channel keeps its own word, so a host that reads only
   // after busy falls never stalls the sequence behind the buffer
   logic [DATA_W-1:0] res_mem [NCH];
   logic [NCH-1:0]    rdy_reg;
   wire  [1:0]        drain_ch = rdy_reg[0] ? 2'd0 :
                                 rdy_reg[1] ? 2'd1 :
                                 rdy_reg[2] ? 2'd2 : 2'd3;
   wire               drain_valid = |rdy_reg;
   wire               drain_push  = drain_valid && in_ready;
   wire  [DATA_W-1:0] drain_data  = res_mem[drain_ch];
   wire  [NCH-1:0]    done_bit    = conv_done ? (4'h1 << ch_reg) : 4'h0;
   wire  [NCH-1:0]    drain_bit   = drain_push ? (4'h1 << drain_ch) : 4'h0;
   // a word not yet handed to the buffer is about to be overwritten
   wire               lost_word   = conv_done && rdy_reg[ch_reg]
                                    && !drain_bit[ch_reg];
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdy_reg <= '0;
      end else begin
         // a new result wins over the drain of the same channel
         rdy_reg <= (rdy_reg & ~drain_bit) | done_bit;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (conv_done) begin
         res_mem[ch_reg] <= coded;
      end
   end

   // ==========================================================
   // result buffer and read port
   // ==========================================================
   logic              out_valid;
   logic [DATA_W-1:0] out_data;
   logic              rd_d_reg;
   logic [DATA_W-1:0] dout_reg;
   logic              doe_reg;
   logic              ovf_reg;
   wire               rd_act  = !bus.cs_n && !bus.rd_n;
   wire               rd_end  = rd_d_reg && !rd_act;
   sas_buf2 #(.W(DATA_W)) u_buf (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .in_valid  (drain_valid),
      .in_ready  (in_ready),
      .in_data   (drain_data),
      .out_valid (out_valid),
      .out_ready (rd_end),
      .out_data  (out_data)
   );
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_d_reg <= 1'b0;
         dout_reg <= '0;
         doe_reg  <= 1'b0;
         ovf_reg  <= 1'b0;
      end else begin
         rd_d_reg <= rd_act;
         doe_reg  <= rd_act;
         dout_reg <= out_valid ? out_data : '0;
         ovf_reg  <= lost_word;
      end
   end
   assign bus.busy      = busy_reg;
   assign bus.eoc_n     = eoc_n_reg;
   assign bus.db_dev_o  = dout_reg;
   assign bus.db_dev_oe = doe_reg;
   assign track_hold_n  = th_reg;
   assign seq_overflow  = ovf_reg;
endmodule

// ===== logic/sas_host.sv
// host end: starts sequences, programs selection, reads results
`timescale 1ns/1ps
module sas_host
   import sas_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   sas_if.host                    bus,
   input  wire logic              cmd_start,
   input  wire logic              cmd_write,
   input  wire logic [NCH-1:0]    cmd_sel,
   input  wire logic              read_each,
   output logic                   cmd_busy,
   output logic [DATA_W-1:0]      res_data,
   output logic                   res_valid
);
   sah_state_e        st_reg;
   logic [7:0]        cnt_reg;
   logic              cs_n_reg;
   logic              rd_n_reg;
   logic              wr_n_reg;
   logic              cv_n_reg;
   logic              oe_reg;
   logic [DATA_W-1:0] do_reg;
   logic [DATA_W-1:0] res_reg;
   logic              rv_reg;
   logic              busy_d_reg;
   logic              eoc_d_reg;
   logic [2:0]        left_reg;
   wire busy_fall = busy_d_reg && !bus.busy;
   wire eoc_fall  = eoc_d_reg && !bus.eoc_n;
   wire seq_idle  = !bus.busy && !busy_d_reg;
   // read after the sequence or on each end-of-conversion
   wire rd_go = read_each ? eoc_fall : busy_fall;
   wire rd_start = (left_reg != 3'd0)
                   && (rd_go || (!read_each && seq_idle));
   wire [2:0] sel_count = {2'b00, cmd_sel[0]} + {2'b00, cmd_sel[1]}
                        + {2'b00, cmd_sel[2]} + {2'b00, cmd_sel[3]};
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg     <= SAH_IDLE;
         cnt_reg    <= 8'd0;
         cs_n_reg   <= 1'b1;
         rd_n_reg   <= 1'b1;
         wr_n_reg   <= 1'b1;
         cv_n_reg   <= 1'b1;
         oe_reg     <= 1'b0;
         do_reg     <= '0;
         res_reg    <= '0;
         rv_reg     <= 1'b0;
         busy_d_reg <= 1'b0;
         eoc_d_reg  <= 1'b1;
         left_reg   <= 3'd0;
      end else begin
         busy_d_reg <= bus.busy;
         eoc_d_reg  <= bus.eoc_n;
         rv_reg     <= 1'b0;
         case (st_reg)
            SAH_IDLE: begin
               if (cmd_write) begin
                  cs_n_reg <= 1'b0;
                  wr_n_reg <= 1'b0;
                  oe_reg   <= 1'b1;
                  do_reg   <= {8'h00, cmd_sel};
                  st_reg   <= SAH_WR;
               end else if (cmd_start) begin
                  cv_n_reg <= 1'b0;
                  cnt_reg  <= 8'd2;
                  left_reg <= sel_count;
                  st_reg   <= SAH_START;
               end
            end
            SAH_WR: begin
               cs_n_reg <= 1'b1;
               wr_n_reg <= 1'b1;
               oe_reg   <= 1'b0;
               st_reg   <= SAH_IDLE;
            end
            SAH_START: begin
               if (cnt_reg == 8'd0) begin
                  cv_n_reg <= 1'b1;
                  // busy must be visible before the read decision
                  cnt_reg  <= 8'd2;
                  st_reg   <= SAH_REL;
               end else begin
                  cnt_reg <= cnt_reg - 8'd1;
               end
            end
            SAH_WAIT: begin
               if (left_reg == 3'd0 && seq_idle) begin
                  cnt_reg <= 8'(ACQ_CYC + READ_GUARD_CYC);
                  st_reg  <= SAH_ACQ;
               end else if (rd_start) begin
                  cs_n_reg <= 1'b0;
                  rd_n_reg <= 1'b0;
                  cnt_reg  <= 8'd3;
                  st_reg   <= SAH_READ;
               end
            end
            SAH_READ: begin
               if (cnt_reg == 8'd0) begin
                  res_reg  <= bus.db_dev_o;
                  rv_reg   <= 1'b1;
                  cs_n_reg <= 1'b1;
                  rd_n_reg <= 1'b1;
                  left_reg <= left_reg - 3'd1;
                  cnt_reg  <= 8'd2;
                  st_reg   <= SAH_REL;
               end else begin
                  cnt_reg <= cnt_reg - 8'd1;
               end
            end
            SAH_REL: begin
               if (cnt_reg == 8'd0) begin
                  st_reg <= SAH_WAIT;
               end else begin
                  cnt_reg <= cnt_reg - 8'd1;
               end
            end
            SAH_ACQ: begin
               // acquisition plus read-quiet guard before next start
               if (cnt_reg == 8'd0) begin
                  st_reg <= SAH_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'd1;
               end
            end
            default: st_reg <= SAH_IDLE;
         endcase
      end
   end
   assign bus.conv_start_n = cv_n_reg;
   assign bus.cs_n         = cs_n_reg;
   assign bus.rd_n         = rd_n_reg;
   assign bus.wr_n         = wr_n_reg;
   assign bus.db_host_o    = do_reg;
   assign bus.db_host_oe   = oe_reg;
   assign cmd_busy         = (st_reg != SAH_IDLE);
   assign res_data         = res_reg;
   assign res_valid        = rv_reg;
endmodule

// ===== verif/sas_assertions.sv
// concurrent checks on the converter/host link
`timescale 1ns/1ps
module sas_assertions
   import sas_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic conv_start_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic busy,
   input wire logic eoc_n,
   input wire logic db_dev_oe,
   input wire logic db_host_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   logic       rd_act;
   logic       rd_reg;
   logic [7:0] idle_reg;
   assign rd_act = !cs_n && !rd_n;
   // saturates, so the first start after reset needs no wait
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_reg   <= 1'b0;
         idle_reg <= 8'hFF;
      end else begin
         rd_reg <= rd_act;
         if (busy) idle_reg <= 8'h00;
         else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
      end
   end
   // ====================
   // checks
   a_busy_on_start: assert property (
      $rose(busy) |-> conv_start_n && (!$past(conv_start_n, 2) ||
         !$past(conv_start_n, 3) || !$past(conv_start_n, 5)))
      else $error("busy rose without a start edge");
   a_busy_min_len: assert property (
      $rose(busy) |=> busy [*8])
      else $error("busy dropped too early");
   a_eoc_two_low: assert property (
      $fell(eoc_n) |=> !eoc_n ##1 eoc_n)
      else $error("end of conversion pulse not two cycles");
   a_eoc_in_seq: assert property (
      $fell(eoc_n) |-> busy)
      else $error("end of conversion outside a sequence");
   a_busy_after_eoc: assert property (
      $fell(busy) |-> !$past(eoc_n, 1) || !$past(eoc_n, 2) ||
         !$past(eoc_n, 3) || !$past(eoc_n, 4))
      else $error("busy fell without a last conversion");
   a_drive_only_read: assert property (
      db_dev_oe |-> rd_act || rd_reg)
      else $error("device drives bus outside a read");
   a_drive_on_read: assert property (
      rd_act && rd_reg |-> db_dev_oe)
      else $error("device silent during a read");
   a_no_contention: assert property (
      !(db_dev_oe && db_host_oe))
      else $error("both ends drive the bus");
   a_host_quiet_read: assert property (
      !rd_n |-> !db_host_oe)
      else $error("host drives bus during a read");
   a_acq_wait: assert property (
      $rose(conv_start_n) |-> idle_reg >= ACQ_CYC)
      else $error("start before acquisition time");
endmodule

// ===== verif/test_simultaneous_adc_sequencer.sv
// self-checking bench: host and converter ends joined by the link
`timescale 1ns/1ps
module test_simultaneous_adc_sequencer;
   import sas_pkg::*;
   logic                  clk_sys = 1'b0;
   logic                  nrst = 1'b0;
   logic                  cmd_start = 1'b0;
   logic                  cmd_write = 1'b0;
   logic                  read_each = 1'b0;
   logic                  hw_sw_select = 1'b0;
   logic                  clock_source_select = 1'b0;
   logic                  ext_conv_clock = 1'b0;
   logic [NCH-1:0]        cmd_sel = 4'h0;
   logic [NCH-1:0]        chan_select_pins = 4'h5;
   logic [NCH*DATA_W-1:0] sample_in = 48'hC3D_5E2_0F7_9A1;
   logic [NCH-1:0]        track_hold_n;
   logic                  seq_overflow;
   int                    ovf_cnt = 0;
   logic                  cmd_busy;
   logic                  res_valid;
   logic [DATA_W-1:0]     res_data;
   logic [DATA_W-1:0]     got_q[$];
   logic                  busy_q = 1'b0;
   logic                  eoc_q = 1'b1;
   int                    errors = 0;
   int                    tests_run = 0;
   int                    busy_cyc = 0;
   int                    eoc_cnt = 0;
   sas_if link ();
   sas_dev u_sas_dev (
      .clk_sys             (clk_sys),
      .nrst                (nrst),
      .bus                 (link),
      .chan_select_pins    (chan_select_pins),
      .hw_sw_select        (hw_sw_select),
      .clock_source_select (clock_source_select),
      .ext_conv_clock      (ext_conv_clock),
      .sample_in           (sample_in),
      .track_hold_n        (track_hold_n),
      .seq_overflow        (seq_overflow)
   );
   sas_host u_sas_host (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .bus       (link),
      .cmd_start (cmd_start),
      .cmd_write (cmd_write),
      .cmd_sel   (cmd_sel),
      .read_each (read_each),
      .cmd_busy  (cmd_busy),
      .res_data  (res_data),
      .res_valid (res_valid)
   );
   sas_assertions u_sas_assertions (
      .clk_sys      (clk_sys),
      .nrst         (nrst),
      .conv_start_n (link.conv_start_n),
      .cs_n         (link.cs_n),
      .rd_n         (link.rd_n),
      .busy         (link.busy),
      .eoc_n        (link.eoc_n),
      .db_dev_oe    (link.db_dev_oe),
      .db_host_oe   (link.db_host_oe)
   );
   always #2.5 clk_sys = ~clk_sys;
   // free-running, 8 system cycles a period, never on a rising system edge, always on a falling one
   always #20 ext_conv_clock = ~ext_conv_clock;
   // ====================
   // compare and closing tasks
   task automatic chk_v(input logic [DATA_W-1:0] got,
                        input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi) begin
         errors++;
         $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic finish_test;
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wait_host(input logic lvl, input int lim);
      int k;
      k = 0;
      while (cmd_busy !== lvl && k < lim) begin
         @(posedge clk_sys) #1;
         k++;
      end
      if (k >= lim) begin
         errors++;
         $display("[ERR] %0t host wait timed out", $time);
      end
   endtask
   // ====================
   // host command tasks
   task automatic write_sel(input logic [NCH-1:0] sel);
      @(posedge clk_sys) #1;
      cmd_sel = sel;
      cmd_write = 1'b1;
      wait_host(1'b1, 20);
      cmd_write = 1'b0;
      wait_host(1'b0, 200);
   endtask
   task automatic start_seq(input logic [NCH-1:0] sel);
      got_q.delete();
      busy_cyc = 0;
      eoc_cnt = 0;
      @(posedge clk_sys) #1;
      cmd_sel = sel;
      cmd_start = 1'b1;
      wait_host(1'b1, 20);
      cmd_start = 1'b0;
   endtask
   // per-channel busy span bounds given by lo and hi
   task automatic run_seq(input logic [NCH-1:0] sel, input int lo,
                          input int hi);
      int n;
      n = 0;
      start_seq(sel);
      wait_host(1'b0, 9000);
      repeat (2) @(posedge clk_sys);
      #1;
      for (int c = 0; c < NCH; c++) begin
         if (sel[c]) begin
            n++;
            chk_v(got_q.size() != 0 ? got_q.pop_front() : 12'hXXX,
                  sample_in[c*DATA_W +: DATA_W] ^ 12'h800);
         end
      end
      chk_n(got_q.size(), 0, 0);
      chk_n(eoc_cnt, n, n);
      chk_n(busy_cyc, n * lo, n * hi + 8);
   endtask
   always @(posedge clk_sys) begin
      if (res_valid === 1'b1) got_q.push_back(res_data);
      if (seq_overflow === 1'b1) ovf_cnt++;
      if (link.busy === 1'b1) begin
         busy_cyc++;
         chk_v({8'h00, track_hold_n}, 12'h000);
      end
      if (busy_q === 1'b1 && link.busy !== 1'b1) begin
         chk_v({8'h00, track_hold_n}, 12'h00F);
      end
      if (eoc_q === 1'b1 && link.eoc_n === 1'b0) eoc_cnt++;
      busy_q <= link.busy;
      eoc_q <= link.eoc_n;
   end
   initial begin
      #100000;
      errors++;
      finish_test();
   end
   // ====================
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      // pins changed mid-run must not reach this sequence
      fork
         begin
            repeat (40) @(posedge clk_sys);
            #1;
            chan_select_pins = 4'hF;
         end
      join_none
      run_seq(4'h5, CONV_CYC, CONV_CYC + 4);
      hw_sw_select = 1'b1;
      read_each = 1'b1;
      run_seq(CHSEL_RST, CONV_CYC, CONV_CYC + 4);
      write_sel(4'h6);
      run_seq(4'h6, CONV_CYC, CONV_CYC + 4);
      write_sel(4'h9);
      clock_source_select = 1'b1;
      read_each = 1'b0;
      run_seq(4'h9, EXT_CONV_CYC * 8 - 8, EXT_CONV_CYC * 8 + 12);
      hw_sw_select = 1'b0;
      chan_select_pins = 4'h0;
      start_seq(4'h0);
      repeat (60) @(posedge clk_sys);
      #1;
      chk_n(busy_cyc + eoc_cnt + got_q.size(), 0, 0);
      chk_n(ovf_cnt, 0, 0);
      finish_test();
   end
endmodule
